// *** logic/stsg_pkg.sv ***
// Purpose: shared constants and command codes for the status register group
// Assumes: one 50 MHz clock, commands arrive already decoded
// Notes: masks give the bits that may hold a one in each writable register
package stsg_pkg;

    // register width
    localparam int STSG_W = 16;

    // writable bits of each writable register
    localparam logic [15:0] OPER_ENAB_MASK = 16'h0030;
    localparam logic [15:0] OPER_FALL_MASK = 16'h0030;
    localparam logic [15:0] OPER_RISE_MASK = 16'h0030;
    localparam logic [15:0] QUES_ENAB_MASK = 16'h0400;

    // preset and reset values
    localparam logic [15:0] OPER_ENAB_PRESET = 16'h0000;
    localparam logic [15:0] OPER_FALL_PRESET = 16'h0000;
    localparam logic [15:0] OPER_RISE_PRESET = 16'h0030;
    localparam logic [15:0] QUES_ENAB_PRESET = 16'h0000;
    localparam logic [15:0] EVENT_CLEARED = 16'h0000;

    // fixed transition filters of the questionable group
    localparam logic [15:0] QUES_RISE_FIXED = 16'hFFFF;
    localparam logic [15:0] QUES_FALL_FIXED = 16'h0000;

    // latency from command to reply, in clock cycles
    localparam int REPLY_LATENCY = 1;

    // decoded status commands
    typedef enum logic [3:0] {
        CMD_NONE,
        CMD_OPER_EVENT_Q,
        CMD_OPER_COND_Q,
        CMD_OPER_ENAB_W,
        CMD_OPER_ENAB_Q,
        CMD_OPER_FALL_W,
        CMD_OPER_FALL_Q,
        CMD_OPER_RISE_W,
        CMD_OPER_RISE_Q,
        CMD_QUES_EVENT_Q,
        CMD_QUES_COND_Q,
        CMD_QUES_ENAB_W,
        CMD_QUES_ENAB_Q,
        CMD_PRESET,
        CMD_CLEAR_STATUS
    } stsg_cmd_e;

endpackage

// *** logic/stsg_grp_if.sv ***
// Purpose: carries one status group between the top and its event logic
// Assumes: both ends run on the same clock
// Notes: the top drives controls, the group returns event and summary
`timescale 1ns/100ps
interface stsg_grp_if;
    logic [15:0] cond;
    logic [15:0] rise_filt;
    logic [15:0] fall_filt;
    logic [15:0] enab;
    logic clear;
    logic [15:0] event_val;
    logic summary;

    // control side
    modport ctrl (
        output cond,
        output rise_filt,
        output fall_filt,
        output enab,
        output clear,
        input event_val,
        input summary
    );

    // event logic side
    modport grp (
        input cond,
        input rise_filt,
        input fall_filt,
        input enab,
        input clear,
        output event_val,
        output summary
    );
endinterface

// *** logic/stsg_group.sv ***
// Purpose: edge detection and sticky event bits of one status group
// Assumes: condition bits are synchronous to the clock
// Notes: a new event in the clearing cycle survives the clear
`timescale 1ns/100ps
module stsg_group (
    input wire logic i_clk,
    input wire logic i_rst_n,
    stsg_grp_if.grp g
);
    import stsg_pkg::*;

    logic [15:0] cond_prev_ff;
    logic [15:0] event_ff;
    logic [15:0] hit;
    logic [15:0] nxt_event;

    // filtered transitions of the condition bits
    assign hit = (g.cond & ~cond_prev_ff & g.rise_filt)
               | (~g.cond & cond_prev_ff & g.fall_filt); // R10

    // set wins over clear
    assign nxt_event = g.clear ? hit : (event_ff | hit); // R10 R11

    // previous condition, for edge detection
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cond_prev_ff <= 16'h0000;
        else
            cond_prev_ff <= g.cond;
    end

    // sticky event register
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            event_ff <= EVENT_CLEARED;
        else
            event_ff <= nxt_event;
    end

    assign g.event_val = event_ff;
    assign g.summary = |(event_ff & g.enab); // R11

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_event_latch_set: assert property ( // R10
        1'b1 |=> (($past(hit) & ~event_ff) == 16'h0000))
        else $error("filtered transition did not latch an event bit");

    a_event_stays_set: assert property ( // R10
        !g.clear |=> ((($past(event_ff)) & ~event_ff) == 16'h0000))
        else $error("event bit dropped without a clear");

    a_clear_leaves_hits: assert property ( // R11
        g.clear |=> (event_ff == $past(hit)))
        else $error("clear did not leave only the new events");

    // an enabled hit must reach the summary through the event register
    a_summary_gate: assert property ( // R11
        ((hit & g.enab) != 16'h0000) ##1 $stable(g.enab) |-> g.summary)
        else $error("enabled event did not raise the summary");
endmodule

// *** logic/stsg_top.sv ***
// Purpose: operation and questionable status registers behind status commands
// Assumes: commands arrive decoded, one per valid cycle, on the system clock
// Notes: queries answer one cycle after the command with a reply pulse
// Functional notes
// R1: operation event query returns event register
// R2: operation condition query returns live condition
// R3: operation enable keeps only bits 4,5
// R4: fall filter writable, presets zero, bits 4,5
// R5: rise filter presets 48, only bits 4,5
// R6: preset command restores all status registers
// R7: questionable event query returns event register
// R8: questionable condition query returns live condition
// R9: questionable enable keeps only bit 10
// R10: filtered condition edges latch sticky event bits
// R11: event read clears; summary is enabled events
`timescale 1ns/100ps
module stsg_top (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    input wire logic I_CMD_VALID,
    input wire stsg_pkg::stsg_cmd_e I_CMD_CODE,
    input wire logic [15:0] I_CMD_DATA,
    input wire logic [15:0] I_OPER_COND,
    input wire logic [15:0] I_QUES_COND,
    output logic O_REPLY_VALID,
    output logic [15:0] O_REPLY_DATA,
    output logic O_OPER_SUMMARY,
    output logic O_QUES_SUMMARY
);
    import stsg_pkg::*;

    logic [15:0] oper_enab_ff;
    logic [15:0] oper_fall_ff;
    logic [15:0] oper_rise_ff;
    logic [15:0] ques_enab_ff;
    logic reply_valid_ff;
    logic [15:0] reply_data_ff;
    logic [15:0] nxt_reply_data;
    logic cmd_preset;
    logic cmd_clear;
    logic oper_clear;
    logic ques_clear;

    stsg_grp_if oper_if ();
    stsg_grp_if ques_if ();

    // true when the command is a valid one of the given code
    function automatic logic is_cmd(input logic valid, input stsg_cmd_e code,
                                    input stsg_cmd_e want);
        is_cmd = valid && (code == want);
    endfunction

    // true for every command that answers with a value
    function automatic logic is_query(input stsg_cmd_e code);
        unique case (code)
            CMD_OPER_EVENT_Q,
            CMD_OPER_COND_Q,
            CMD_OPER_ENAB_Q,
            CMD_OPER_FALL_Q,
            CMD_OPER_RISE_Q,
            CMD_QUES_EVENT_Q,
            CMD_QUES_COND_Q,
            CMD_QUES_ENAB_Q:
                is_query = 1'b1;
            default:
                is_query = 1'b0;
        endcase
    endfunction

    // out-of-range bits of a write are dropped
    function automatic logic [15:0] masked(input logic [15:0] data,
                                           input logic [15:0] mask);
        masked = data & mask;
    endfunction

    // command strobes shared by several registers
    assign cmd_preset = is_cmd(I_CMD_VALID, I_CMD_CODE, CMD_PRESET); // R6
    assign cmd_clear = is_cmd(I_CMD_VALID, I_CMD_CODE, CMD_CLEAR_STATUS);

    // reading an event register, a clear or a preset empties it
    assign oper_clear = cmd_clear || cmd_preset
                      || is_cmd(I_CMD_VALID, I_CMD_CODE, CMD_OPER_EVENT_Q); // R11
    assign ques_clear = cmd_clear || cmd_preset
                      || is_cmd(I_CMD_VALID, I_CMD_CODE, CMD_QUES_EVENT_Q); // R11

    // operation enable register
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
            oper_enab_ff <= OPER_ENAB_PRESET;
        else if (cmd_preset)
            oper_enab_ff <= OPER_ENAB_PRESET; // R6
        else if (is_cmd(I_CMD_VALID, I_CMD_CODE, CMD_OPER_ENAB_W))
            oper_enab_ff <= masked(I_CMD_DATA, OPER_ENAB_MASK); // R3
    end

    // operation negative-transition filter
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
            oper_fall_ff <= OPER_FALL_PRESET;
        else if (cmd_preset)
            oper_fall_ff <= OPER_FALL_PRESET; // R6
        else if (is_cmd(I_CMD_VALID, I_CMD_CODE, CMD_OPER_FALL_W))
            oper_fall_ff <= masked(I_CMD_DATA, OPER_FALL_MASK); // R4
    end

    // operation positive-transition filter
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
            oper_rise_ff <= OPER_RISE_PRESET;
        else if (cmd_preset)
            oper_rise_ff <= OPER_RISE_PRESET; // R6
        else if (is_cmd(I_CMD_VALID, I_CMD_CODE, CMD_OPER_RISE_W))
            oper_rise_ff <= masked(I_CMD_DATA, OPER_RISE_MASK); // R5
    end

    // questionable enable register
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
            ques_enab_ff <= QUES_ENAB_PRESET;
        else if (cmd_preset)
            ques_enab_ff <= QUES_ENAB_PRESET; // R6
        else if (is_cmd(I_CMD_VALID, I_CMD_CODE, CMD_QUES_ENAB_W))
            ques_enab_ff <= masked(I_CMD_DATA, QUES_ENAB_MASK); // R9
    end

    // operation group wiring
    assign oper_if.cond = I_OPER_COND;
    assign oper_if.rise_filt = oper_rise_ff;
    assign oper_if.fall_filt = oper_fall_ff;
    assign oper_if.enab = oper_enab_ff;
    assign oper_if.clear = oper_clear;

    // questionable group wiring, filters fixed to rising edges
    assign ques_if.cond = I_QUES_COND;
    assign ques_if.rise_filt = QUES_RISE_FIXED;
    assign ques_if.fall_filt = QUES_FALL_FIXED;
    assign ques_if.enab = ques_enab_ff;
    assign ques_if.clear = ques_clear;

    stsg_group u_oper (
        .i_clk (I_SYS_CLK),
        .i_rst_n (I_RST_N),
        .g (oper_if.grp)
    );

    stsg_group u_ques (
        .i_clk (I_SYS_CLK),
        .i_rst_n (I_RST_N),
        .g (ques_if.grp)
    );

    // reply value chosen by the query code
    always_comb
    begin
        nxt_reply_data = 16'h0000;
        unique case (I_CMD_CODE)
            CMD_OPER_EVENT_Q: nxt_reply_data = oper_if.event_val; // R1
            CMD_OPER_COND_Q: nxt_reply_data = I_OPER_COND; // R2
            CMD_OPER_ENAB_Q: nxt_reply_data = oper_enab_ff; // R3
            CMD_OPER_FALL_Q: nxt_reply_data = oper_fall_ff; // R4
            CMD_OPER_RISE_Q: nxt_reply_data = oper_rise_ff; // R5
            CMD_QUES_EVENT_Q: nxt_reply_data = ques_if.event_val; // R7
            CMD_QUES_COND_Q: nxt_reply_data = I_QUES_COND; // R8
            CMD_QUES_ENAB_Q: nxt_reply_data = ques_enab_ff; // R9
            default: nxt_reply_data = 16'h0000;
        endcase
    end

    // reply strobe, one pulse per query
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
            reply_valid_ff <= 1'b0;
        else
            reply_valid_ff <= I_CMD_VALID && is_query(I_CMD_CODE);
    end

    // reply data, held until the next query
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
            reply_data_ff <= 16'h0000;
        else if (I_CMD_VALID && is_query(I_CMD_CODE))
            reply_data_ff <= nxt_reply_data;
    end

    // outputs
    assign O_REPLY_VALID = reply_valid_ff;
    assign O_REPLY_DATA = reply_data_ff;
    assign O_OPER_SUMMARY = oper_if.summary; // R11
    assign O_QUES_SUMMARY = ques_if.summary; // R11

    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_N);

    // write and query steps
    sequence s_oper_enab_wr;
        I_CMD_VALID && I_CMD_CODE == CMD_OPER_ENAB_W;
    endsequence

    sequence s_oper_enab_rd;
        I_CMD_VALID && I_CMD_CODE == CMD_OPER_ENAB_Q;
    endsequence

    sequence s_oper_fall_wr;
        I_CMD_VALID && I_CMD_CODE == CMD_OPER_FALL_W;
    endsequence

    sequence s_oper_fall_rd;
        I_CMD_VALID && I_CMD_CODE == CMD_OPER_FALL_Q;
    endsequence

    sequence s_oper_rise_wr;
        I_CMD_VALID && I_CMD_CODE == CMD_OPER_RISE_W;
    endsequence

    sequence s_oper_rise_rd;
        I_CMD_VALID && I_CMD_CODE == CMD_OPER_RISE_Q;
    endsequence

    property p_reply_of(stsg_cmd_e code, logic [15:0] val);
        (I_CMD_VALID && I_CMD_CODE == code)
            |=> (O_REPLY_VALID && O_REPLY_DATA == $past(val));
    endproperty

    a_oper_event_reply: assert property (p_reply_of(CMD_OPER_EVENT_Q, oper_if.event_val)) // R1
        else $error("operation event reply wrong");

    a_oper_cond_reply: assert property (p_reply_of(CMD_OPER_COND_Q, I_OPER_COND)) // R2
        else $error("operation condition reply wrong");

    a_oper_enab_rt: assert property ( // R3
        s_oper_enab_wr ##1 (s_oper_enab_rd and !cmd_preset)
            |=> O_REPLY_DATA == ($past(I_CMD_DATA, 2) & 16'h0030))
        else $error("operation enable write did not read back masked");

    a_oper_fall_mask: assert property ( // R4
        (oper_fall_ff & 16'hFFCF) == 16'h0000)
        else $error("fall filter holds a forbidden bit");

    a_oper_rise_mask: assert property ( // R5
        (oper_rise_ff & 16'hFFCF) == 16'h0000)
        else $error("rise filter holds a forbidden bit");

    a_preset_values: assert property ( // R6
        cmd_preset |=> (oper_enab_ff == 16'h0000 && oper_fall_ff == 16'h0000
                        && oper_rise_ff == 16'h0030 && ques_enab_ff == 16'h0000))
        else $error("preset left a register off its preset value");

    a_ques_event_reply: assert property (p_reply_of(CMD_QUES_EVENT_Q, ques_if.event_val)) // R7
        else $error("questionable event reply wrong");

    a_ques_cond_reply: assert property (p_reply_of(CMD_QUES_COND_Q, I_QUES_COND)) // R8
        else $error("questionable condition reply wrong");

    a_ques_enab_mask: assert property ( // R9
        is_cmd(I_CMD_VALID, I_CMD_CODE, CMD_QUES_ENAB_W) && !cmd_preset
            |=> ques_enab_ff == ($past(I_CMD_DATA) & 16'h0400))
        else $error("questionable enable not masked to bit 10");

    a_write_no_reply: assert property ( // R3
        (I_CMD_VALID && !is_query(I_CMD_CODE)) |=> !O_REPLY_VALID)
        else $error("write command produced a reply");

    a_oper_enab_reply: assert property (p_reply_of(CMD_OPER_ENAB_Q, oper_enab_ff)) // R3
        else $error("operation enable reply wrong");

    a_oper_fall_reply: assert property (p_reply_of(CMD_OPER_FALL_Q, oper_fall_ff)) // R4
        else $error("fall filter reply wrong");

    a_oper_rise_reply: assert property (p_reply_of(CMD_OPER_RISE_Q, oper_rise_ff)) // R5
        else $error("rise filter reply wrong");

    a_ques_enab_reply: assert property (p_reply_of(CMD_QUES_ENAB_Q, ques_enab_ff)) // R9
        else $error("questionable enable reply wrong");

    a_oper_enab_mask: assert property ( // R3
        (oper_enab_ff & 16'hFFCF) == 16'h0000)
        else $error("operation enable holds a forbidden bit");

    a_ques_enab_bits: assert property ( // R9
        (ques_enab_ff & 16'hFBFF) == 16'h0000)
        else $error("questionable enable holds a forbidden bit");

    a_oper_fall_rt: assert property ( // R4
        s_oper_fall_wr ##1 s_oper_fall_rd
            |=> O_REPLY_DATA == ($past(I_CMD_DATA, 2) & 16'h0030))
        else $error("fall filter write did not read back masked");

    a_oper_rise_rt: assert property ( // R5
        s_oper_rise_wr ##1 s_oper_rise_rd
            |=> O_REPLY_DATA == ($past(I_CMD_DATA, 2) & 16'h0030))
        else $error("rise filter write did not read back masked");

    a_reply_data_hold: assert property ( // R1
        !(I_CMD_VALID && is_query(I_CMD_CODE)) |=> $stable(O_REPLY_DATA))
        else $error("reply data changed without a query");

    a_clear_keeps_cfg: assert property ( // R11
        cmd_clear |=> ($stable(oper_enab_ff) && $stable(oper_fall_ff)
                       && $stable(oper_rise_ff) && $stable(ques_enab_ff)))
        else $error("clear-status touched an enable or filter");
endmodule

// *** testbench/stsg_host.sv ***
// Purpose: remote host model issuing decoded status commands
// Assumes: commands are launched one small delay after a rising edge
// Notes: each idle cycle inverts data and code, so two idles in a row put the stale values back on the bus
`timescale 1ns/100ps
module stsg_host
    import stsg_pkg::*;
(
    input wire logic i_clk,
    output logic o_cmd_valid,
    output stsg_cmd_e o_cmd_code,
    output logic [15:0] o_cmd_data
);
    // quiet bus at time zero
    initial
    begin
        o_cmd_valid = 1'b0;
        o_cmd_code = CMD_NONE;
        o_cmd_data = 16'h0000;
    end

    // one command, held across its taking edge
    task automatic send(input stsg_cmd_e code, input logic [15:0] data);
        o_cmd_valid = 1'b1;
        o_cmd_code = code;
        o_cmd_data = data;
        @(posedge i_clk);
        #1;
    endtask

    // one empty cycle with garbage on the qualifiers
    task automatic idle();
        o_cmd_valid = 1'b0;
        o_cmd_code = stsg_cmd_e'(o_cmd_code ^ 4'hF);
        o_cmd_data = ~o_cmd_data;
        @(posedge i_clk);
        #1;
    endtask
endmodule

// *** testbench/scpi_status_register_group_tb.sv ***
// Purpose: self-checking bench for the status register group
// Assumes: reply visible right after the taking edge, checked at the falling edge
// Notes: a cycle model in the bench predicts replies, events and summaries
`timescale 1ns/100ps
module scpi_status_register_group_tb;
    import stsg_pkg::*;
    logic clk, rst_n, vld, rv, osum, qsum;
    stsg_cmd_e code, m_last;
    logic [15:0] oc, qc, data, rd;
    logic [15:0] m_oen, m_ofa, m_ori, m_qen, m_oev, m_qev, m_op, m_qp, m_rd, n_oev, n_qev;
    logic m_rv;
    logic [31:0] seed, r;
    int miscompares, num_checks, cyc;
    stsg_cmd_e qlist[4] = '{CMD_OPER_ENAB_Q, CMD_OPER_FALL_Q, CMD_OPER_RISE_Q, CMD_QUES_ENAB_Q};

    stsg_top i_stsg_top (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_CMD_VALID(vld), .I_CMD_CODE(code),
        .I_CMD_DATA(data), .I_OPER_COND(oc), .I_QUES_COND(qc), .O_REPLY_VALID(rv),
        .O_REPLY_DATA(rd), .O_OPER_SUMMARY(osum), .O_QUES_SUMMARY(qsum));
    stsg_host i_stsg_host (.i_clk(clk), .o_cmd_valid(vld), .o_cmd_code(code), .o_cmd_data(data));

    // clock, 20 ns period
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        if (miscompares == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // expected state, stepped on every rising edge
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            m_oen = 16'h0000; m_ofa = 16'h0000; m_ori = 16'h0030; m_qen = 16'h0000;
            m_oev = 16'h0000; m_qev = 16'h0000; m_op = 16'h0000; m_qp = 16'h0000;
            m_rd = 16'h0000; m_rv = 1'b0; m_last = CMD_NONE;
        end
        else
        begin
            m_last = vld ? code : CMD_NONE;
            // set wins over the clear of the same cycle
            n_oev = ((vld && code inside {CMD_OPER_EVENT_Q, CMD_PRESET, CMD_CLEAR_STATUS}) ? 16'h0000 : m_oev)
                | (oc & ~m_op & m_ori) | (~oc & m_op & m_ofa);
            n_qev = ((vld && code inside {CMD_QUES_EVENT_Q, CMD_PRESET, CMD_CLEAR_STATUS}) ? 16'h0000 : m_qev)
                | (qc & ~m_qp);
            m_rv = vld && (code inside {CMD_OPER_EVENT_Q, CMD_OPER_COND_Q, CMD_OPER_ENAB_Q, CMD_OPER_FALL_Q,
                CMD_OPER_RISE_Q, CMD_QUES_EVENT_Q, CMD_QUES_COND_Q, CMD_QUES_ENAB_Q});
            if (vld)
            begin
                case (code)
                    CMD_OPER_EVENT_Q: m_rd = m_oev;
                    CMD_OPER_COND_Q: m_rd = oc;
                    CMD_OPER_ENAB_W: m_oen = data & 16'h0030;
                    CMD_OPER_ENAB_Q: m_rd = m_oen;
                    CMD_OPER_FALL_W: m_ofa = data & 16'h0030;
                    CMD_OPER_FALL_Q: m_rd = m_ofa;
                    CMD_OPER_RISE_W: m_ori = data & 16'h0030;
                    CMD_OPER_RISE_Q: m_rd = m_ori;
                    CMD_QUES_EVENT_Q: m_rd = m_qev;
                    CMD_QUES_COND_Q: m_rd = qc;
                    CMD_QUES_ENAB_W: m_qen = data & 16'h0400;
                    CMD_QUES_ENAB_Q: m_rd = m_qen;
                    CMD_PRESET:
                    begin
                        m_oen = 16'h0000; m_ofa = 16'h0000; m_ori = 16'h0030; m_qen = 16'h0000;
                    end
                    default: ;
                endcase
            end
            m_oev = n_oev; m_qev = n_qev; m_op = oc; m_qp = qc;
        end
    end

    // outputs compared where settled
    always @(negedge clk)
    begin
        if (rst_n)
        begin
            chk_flag(rv, m_rv);
            case (m_last)
                CMD_OPER_EVENT_Q: chk(rd, m_rd);
                CMD_OPER_COND_Q: chk(rd, m_rd);
                CMD_OPER_ENAB_Q: chk(rd, m_rd);
                CMD_OPER_FALL_Q: chk(rd, m_rd);
                CMD_OPER_RISE_Q: chk(rd, m_rd);
                CMD_QUES_EVENT_Q: chk(rd, m_rd);
                CMD_QUES_COND_Q: chk(rd, m_rd);
                CMD_QUES_ENAB_Q: chk(rd, m_rd);
                default: chk(rd, m_rd);
            endcase
            chk_flag(osum, |(m_oev & m_oen));
            chk_flag(qsum, |(m_qev & m_qen));
        end
    end

    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            miscompares++;
            stop_test();
        end
    end

    // random phase: conditions and commands
    task automatic rand_run(input int n);
        repeat (n)
        begin
            r = xs();
            if (r[21:20] == 2'b00)
            begin
                oc = r[31:16];
                qc = r[15:0] ^ r[31:16];
            end
            r = xs();
            if (r[19:18] == 2'b00)
                i_stsg_host.idle();
            else
                i_stsg_host.send(stsg_cmd_e'(r[3:0] == 4'hF ? 4'h0 : r[3:0]), r[31:16]);
        end
    endtask

    // main sequence
    initial
    begin
        oc = 16'h0000;
        qc = 16'h0000;
        rst_n = 1'b0;
        seed = 32'h00013FA4;
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        for (int i = 0; i < 4; i++) i_stsg_host.send(qlist[i], 16'h0000);
        for (int i = 0; i < 15; i++) i_stsg_host.send(stsg_cmd_e'(i), 16'hFFFF);
        for (int i = 0; i < 4; i++) i_stsg_host.send(qlist[i], 16'h0000);
        // edge in the same cycle as the event read
        oc = 16'h0010;
        i_stsg_host.send(CMD_OPER_EVENT_Q, 16'h0000);
        oc = 16'h0000;
        i_stsg_host.send(CMD_OPER_EVENT_Q, 16'h0000);
        i_stsg_host.send(CMD_OPER_EVENT_Q, 16'h0000);
        rand_run(600);
        // second reset in mid-run
        i_stsg_host.idle();
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        for (int i = 0; i < 4; i++) i_stsg_host.send(qlist[i], 16'h0000);
        rand_run(300);
        i_stsg_host.idle();
        stop_test();
    end
endmodule
